// *** shared/ast_defines.vh ***
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH

// oversampling and sample positions inside one bit (zero based)
`define AST_OVERSAMPLE       16
`define AST_SUB_LAST         4'hf
`define AST_SUB_S3           4'h2
`define AST_SUB_S5           4'h4
`define AST_SUB_S7           4'h6
`define AST_SUB_S8           4'h7
`define AST_SUB_S9           4'h8
`define AST_SUB_S10          4'h9

// frame lengths in bits: start + data + stop
`define AST_FRAME_LEN_8      4'ha
`define AST_FRAME_LEN_9      4'hb
`define AST_DATA_LEN_8       4'h8
`define AST_DATA_LEN_9       4'h9
`define AST_ONE_BIT          4'h1

// conventional prescaler factors
`define AST_PR_SEL0          4'h1
`define AST_PR_SEL1          4'h3
`define AST_PR_SEL2          4'h4
`define AST_PR_SEL3          4'hd

// reset values
`define AST_TX_BUFFER_EMPTY_RST         1'b1
`define AST_TC_RST           1'b1

// transmit fifo shape
`define AST_FIFO_WIDTH       9
`define AST_FIFO_DEPTH       16
`define AST_FIFO_AW          4

// receiver states
`define AST_RX_HUNT          2'h0
`define AST_RX_START         2'h1
`define AST_RX_BITS          2'h2

`endif

// *** rtl/ast_transceiver.v ***
`timescale 1ns/100ps
`default_nettype none
`include "ast_defines.vh"

module ast_fifo #(
    parameter WIDTH = `AST_FIFO_WIDTH,
    parameter DEPTH = `AST_FIFO_DEPTH,
    parameter AW    = `AST_FIFO_AW
) (
    input  wire             clk_i,     // clock
    input  wire             nrst_i,    // async reset, active low
    input  wire [WIDTH-1:0] in_data_i, // fill data
    input  wire             in_valid_i,// fill valid
    output wire             in_ready_o,// not full
    output wire [WIDTH-1:0] out_data_o,// head word
    output wire             out_valid_o,// not empty
    input  wire             out_ready_i // drain
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module ast_transceiver #(
    parameter FIFO_DEPTH = `AST_FIFO_DEPTH,
    parameter FIFO_AW    = `AST_FIFO_AW
) (
    input  wire       clk_i,                // 100 MHz clock
    input  wire       nrst_i,               // async reset, active low
    input  wire       word9_i,              // word length: 1 = 9 bits
    input  wire       tx_enable_i,          // transmitter enable
    input  wire       rx_enable_i,          // receiver enable
    input  wire       send_break_i,         // send break frames
    input  wire       wake_method_i,        // 0 idle wake, 1 address wake
    input  wire       rx_mute_set_i,        // pulse: enter mute
    input  wire [1:0] prescale_sel_i,       // prescaler 1/3/4/13
    input  wire [2:0] tx_rate_sel_i,        // tx power of two divider
    input  wire [2:0] rx_rate_sel_i,        // rx power of two divider
    input  wire [7:0] tx_fine_prescaler_i,  // tx fine prescaler, 0 = off
    input  wire [7:0] rx_fine_prescaler_i,  // rx fine prescaler, 0 = off
    input  wire       tx_empty_irq_en_i,    // tx empty interrupt enable
    input  wire       tx_complete_irq_en_i, // tx complete interrupt enable
    input  wire       rx_irq_en_i,          // rx full / overrun enable
    input  wire       idle_irq_en_i,        // idle interrupt enable
    input  wire       irq_mask_i,           // cpu interrupt mask, 1 masks
    input  wire       status_rd_i,          // pulse: status register read
    input  wire       data_rd_i,            // pulse: data register read
    input  wire [8:0] tx_data_i,            // bit 8 is tx_ninth_bit
    input  wire       tx_valid_i,           // data write valid
    output wire       tx_ready_o,           // fifo can take a word
    input  wire       serial_rx_pin_i,      // serial input
    output wire       tx_pin_o,             // serial output
    output wire       tx_pin_oe_o,          // pin owned by serial function
    output reg  [7:0] rx_data_o,            // rx_buffer
    output reg        rx_ninth_bit_o,       // received ninth bit
    output reg        tx_buffer_empty_o,    // status flag
    output reg        tx_complete_o,        // status flag
    output reg        rx_full_o,            // status flag
    output reg        idle_o,               // status flag
    output reg        overrun_o,            // status flag
    output reg        noise_flag_o,         // status flag
    output reg        framing_error_o,      // status flag
    output reg        rx_mute_o,            // mute state
    output wire       irq_o                 // interrupt request, level
);
    // full baud divisor: prescaler * 2^rate * fine
    function [18:0] divisor;
        input [1:0] psel;
        input [2:0] rsel;
        input [7:0] fine;
        reg   [3:0]  pr;
        reg   [10:0] sh;
        reg   [7:0]  f;
        begin
            case (psel)
                2'h0:    pr = `AST_PR_SEL0;
                2'h1:    pr = `AST_PR_SEL1;
                2'h2:    pr = `AST_PR_SEL2;
                default: pr = `AST_PR_SEL3;
            endcase
            sh = {7'h00, pr} << rsel;
            f  = (fine == 8'h00) ? 8'h01 : fine;
            divisor = {8'h00, sh} * {11'h000, f};
        end
    endfunction

    // 16x sample ticks, index 0 tx, 1 rx
    wire [18:0] div_val [0:1];
    wire [1:0]  dir_en;
    wire [1:0]  tick;
    assign div_val[0] = divisor(prescale_sel_i, tx_rate_sel_i, tx_fine_prescaler_i);
    assign div_val[1] = divisor(prescale_sel_i, rx_rate_sel_i, rx_fine_prescaler_i);

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_baud
            reg [18:0] cnt_reg;
            assign tick[g] = dir_en[g] & (cnt_reg == 19'h0_0000);
            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    cnt_reg <= 19'h0_0000;
                end else if (!dir_en[g] || cnt_reg == 19'h0_0000) begin
                    cnt_reg <= div_val[g] - 19'h0_0001;
                end else begin
                    cnt_reg <= cnt_reg - 19'h0_0001;
                end
            end
        end
    endgenerate

    wire [3:0] flen = word9_i ? `AST_FRAME_LEN_9 : `AST_FRAME_LEN_8;
    wire [3:0] dlen = word9_i ? `AST_DATA_LEN_9 : `AST_DATA_LEN_8;

    // transmit fifo in the write path
    wire [8:0] fifo_data;
    wire       fifo_valid;
    wire       fifo_pop;
    reg        tdr_full_reg;
    assign fifo_pop = fifo_valid & ~tdr_full_reg & tx_enable_i;

    ast_fifo #(
        .WIDTH (`AST_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // transmitter
    reg  [8:0]  tdr_reg;
    reg         tx_busy_reg;
    reg  [10:0] tx_shift_reg;
    reg  [3:0]  tx_left_reg;
    reg  [3:0]  tx_sub_reg;
    reg         idle_pend_reg;
    reg         brk_sent_reg;
    reg         te_d_reg;
    reg         arm_tx_reg;
    // tx divider keeps running until a cut frame has finished
    assign dir_en = {rx_enable_i, tx_enable_i | tx_busy_reg};
    wire        tx_bit_end   = tx_busy_reg & tick[0] & (tx_sub_reg == `AST_SUB_LAST);
    wire        tx_frame_end = tx_bit_end & (tx_left_reg == `AST_ONE_BIT);
    wire        tx_can_load  = ~tx_busy_reg | tx_frame_end;
    wire [10:0] tx_word      = word9_i ? {1'b1, tdr_reg, 1'b0} : {2'b11, tdr_reg[7:0], 1'b0};

    assign tx_pin_o    = tx_busy_reg ? tx_shift_reg[0] : 1'b1;
    assign tx_pin_oe_o = tx_enable_i | rx_enable_i;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tdr_reg           <= 9'h000;
            tdr_full_reg      <= 1'b0;
            tx_buffer_empty_o <= `AST_TX_BUFFER_EMPTY_RST;
            tx_complete_o     <= `AST_TC_RST;
            tx_busy_reg       <= 1'b0;
            tx_shift_reg      <= 11'h7ff;
            tx_left_reg       <= 4'h0;
            tx_sub_reg        <= 4'h0;
            idle_pend_reg     <= 1'b0;
            brk_sent_reg      <= 1'b0;
            te_d_reg          <= 1'b0;
            arm_tx_reg        <= 1'b0;
        end else begin
            te_d_reg <= tx_enable_i;
            if (status_rd_i) begin
                arm_tx_reg <= 1'b1;
            end
            if (fifo_pop) begin
                tdr_reg      <= fifo_data;
                tdr_full_reg <= 1'b1;
                if (arm_tx_reg) begin
                    tx_buffer_empty_o <= 1'b0;
                    tx_complete_o     <= 1'b0;
                    arm_tx_reg        <= status_rd_i;
                end
            end
            if (tx_enable_i & ~te_d_reg) begin
                idle_pend_reg <= 1'b1;
            end
            if (~tx_enable_i & te_d_reg) begin
                tdr_full_reg      <= 1'b0;
                tx_buffer_empty_o <= 1'b1;
            end
            if (tx_busy_reg & tick[0]) begin
                tx_sub_reg <= tx_sub_reg + 4'h1;
            end
            if (tx_bit_end) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                tx_left_reg  <= tx_left_reg - 4'h1;
            end
            if (tx_can_load) begin
                tx_sub_reg <= 4'h0;
                if (!tx_enable_i) begin
                    tx_busy_reg <= 1'b0;
                    if (tx_frame_end) begin
                        tx_complete_o <= 1'b1;
                    end
                end else if (idle_pend_reg) begin
                    tx_busy_reg   <= 1'b1;
                    tx_shift_reg  <= 11'h7ff;
                    tx_left_reg   <= flen;
                    idle_pend_reg <= 1'b0;
                end else if (send_break_i) begin
                    tx_busy_reg  <= 1'b1;
                    tx_shift_reg <= 11'h000;
                    tx_left_reg  <= flen;
                    brk_sent_reg <= 1'b1;
                end else if (brk_sent_reg) begin
                    tx_busy_reg  <= 1'b1;
                    tx_shift_reg <= 11'h7ff;
                    tx_left_reg  <= `AST_ONE_BIT;
                    brk_sent_reg <= 1'b0;
                end else if (tdr_full_reg) begin
                    tx_busy_reg       <= 1'b1;
                    tx_shift_reg      <= tx_word;
                    tx_left_reg       <= flen;
                    tdr_full_reg      <= 1'b0;
                    tx_buffer_empty_o <= 1'b1;
                end else begin
                    tx_busy_reg <= 1'b0;
                    if (tx_frame_end) begin
                        tx_complete_o <= 1'b1;
                    end
                end
            end
        end
    end

    // receiver
    reg  [1:0] rx_state_reg;
    reg  [2:0] rx_hist_reg;
    reg  [3:0] rx_sub_reg;
    reg  [2:0] rx_samp_reg;
    reg        rx_edge_noise_reg;
    reg  [3:0] rx_bitn_reg;
    reg  [8:0] rx_shift_reg;
    reg        rx_nf_acc_reg;
    reg        nf_hidden_reg;
    reg  [7:0] idle_cnt_reg;
    reg        idle_armed_reg;
    reg        arm_rx_reg;
    wire       rx_pin   = serial_rx_pin_i;
    wire       maj      = (rx_samp_reg[0] & rx_samp_reg[1]) | (rx_samp_reg[0] & rx_samp_reg[2])
                          | (rx_samp_reg[1] & rx_samp_reg[2]);
    wire       disagree = (rx_samp_reg != 3'h0) & (rx_samp_reg != 3'h7);
    wire       bit_end  = tick[1] & (rx_sub_reg == `AST_SUB_LAST);
    wire [8:0] rx_word  = word9_i ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
    wire       rx_msb   = word9_i ? rx_shift_reg[8] : rx_shift_reg[8];
    wire [7:0] idle_len = {flen, 4'h0} - 8'h01;
    wire       rx_done  = (rx_state_reg == `AST_RX_BITS) & bit_end & (rx_bitn_reg == dlen);
    wire       idle_hit = (rx_state_reg == `AST_RX_HUNT) & tick[1] & rx_pin
                          & idle_armed_reg & (idle_cnt_reg == idle_len);
    wire       deliver  = rx_done & (~rx_mute_o | (wake_method_i & rx_msb));

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_state_reg      <= `AST_RX_HUNT;
            rx_hist_reg       <= 3'h0;
            rx_sub_reg        <= 4'h0;
            rx_samp_reg       <= 3'h0;
            rx_edge_noise_reg <= 1'b0;
            rx_bitn_reg       <= 4'h0;
            rx_shift_reg      <= 9'h000;
            rx_nf_acc_reg     <= 1'b0;
            nf_hidden_reg     <= 1'b0;
            idle_cnt_reg      <= 8'h00;
            idle_armed_reg    <= 1'b1;
            arm_rx_reg        <= 1'b0;
            rx_data_o         <= 8'h00;
            rx_ninth_bit_o    <= 1'b0;
            rx_full_o         <= 1'b0;
            idle_o            <= 1'b0;
            overrun_o         <= 1'b0;
            noise_flag_o      <= 1'b0;
            framing_error_o   <= 1'b0;
            rx_mute_o         <= 1'b0;
        end else begin
            if (status_rd_i) begin
                arm_rx_reg <= 1'b1;
            end
            if (data_rd_i & arm_rx_reg) begin
                rx_full_o       <= 1'b0;
                overrun_o       <= 1'b0;
                noise_flag_o    <= 1'b0;
                framing_error_o <= 1'b0;
                idle_o          <= 1'b0;
                arm_rx_reg      <= status_rd_i;
            end
            if (!rx_enable_i) begin
                rx_state_reg   <= `AST_RX_HUNT;
                rx_hist_reg    <= 3'h0;
                idle_cnt_reg   <= 8'h00;
                idle_armed_reg <= 1'b1;
            end else if (tick[1]) begin
                rx_sub_reg <= rx_sub_reg + 4'h1;
                if (rx_sub_reg == `AST_SUB_S8) begin
                    rx_samp_reg[0] <= rx_pin;
                end
                if (rx_sub_reg == `AST_SUB_S9) begin
                    rx_samp_reg[1] <= rx_pin;
                end
                if (rx_sub_reg == `AST_SUB_S10) begin
                    rx_samp_reg[2] <= rx_pin;
                end
                case (rx_state_reg)
                    `AST_RX_HUNT: begin
                        rx_hist_reg       <= {rx_hist_reg[1:0], rx_pin};
                        idle_cnt_reg      <= rx_pin ? idle_cnt_reg + 8'h01 : 8'h00;
                        rx_sub_reg        <= 4'h1;
                        rx_edge_noise_reg <= 1'b0;
                        if (idle_hit) begin
                            idle_armed_reg <= 1'b0;
                        end
                        if (rx_hist_reg == 3'h7 && !rx_pin) begin
                            rx_state_reg <= `AST_RX_START;
                        end
                    end
                    `AST_RX_START: begin
                        if ((rx_sub_reg == `AST_SUB_S3 || rx_sub_reg == `AST_SUB_S5
                             || rx_sub_reg == `AST_SUB_S7) && rx_pin) begin
                            rx_edge_noise_reg <= 1'b1;
                        end
                        if (bit_end) begin
                            if (maj) begin
                                rx_state_reg  <= `AST_RX_HUNT;
                                rx_hist_reg   <= 3'h0;
                                nf_hidden_reg <= 1'b1;
                            end else begin
                                rx_state_reg  <= `AST_RX_BITS;
                                rx_bitn_reg   <= 4'h0;
                                rx_nf_acc_reg <= nf_hidden_reg | rx_edge_noise_reg | disagree;
                            end
                        end
                    end
                    `AST_RX_BITS: begin
                        if (bit_end) begin
                            rx_nf_acc_reg <= rx_nf_acc_reg | disagree;
                            if (rx_bitn_reg != dlen) begin
                                rx_shift_reg <= {maj, rx_shift_reg[8:1]};
                                rx_bitn_reg  <= rx_bitn_reg + 4'h1;
                            end else begin
                                rx_state_reg   <= `AST_RX_HUNT;
                                rx_hist_reg    <= {3{maj}};
                                idle_cnt_reg   <= 8'h00;
                                idle_armed_reg <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        rx_state_reg <= `AST_RX_HUNT;
                    end
                endcase
            end
            if (deliver) begin
                nf_hidden_reg <= 1'b0;
                // a clear in the same cycle frees the buffer, delivery wins
                if (rx_full_o && !(data_rd_i && arm_rx_reg)) begin
                    overrun_o <= 1'b1;
                end else begin
                    rx_data_o       <= rx_word[7:0];
                    rx_ninth_bit_o  <= rx_word[8];
                    rx_full_o       <= 1'b1;
                    noise_flag_o    <= rx_nf_acc_reg | disagree;
                    framing_error_o <= ~maj;
                end
            end
            if (idle_hit) begin
                if (!rx_mute_o) begin
                    idle_o <= 1'b1;
                end else if (!wake_method_i) begin
                    rx_mute_o <= 1'b0;
                end
            end
            if (rx_done & rx_mute_o & wake_method_i & rx_msb) begin
                rx_mute_o <= 1'b0;
            end
            if (rx_mute_set_i) begin
                rx_mute_o <= 1'b1;
            end
        end
    end

    assign irq_o = ~irq_mask_i & ((tx_empty_irq_en_i & tx_buffer_empty_o)
                 | (tx_complete_irq_en_i & tx_complete_o)
                 | (~rx_mute_o & rx_irq_en_i & (rx_full_o | overrun_o))
                 | (~rx_mute_o & idle_irq_en_i & idle_o));
endmodule

`default_nettype wire

// *** sim/ast_remote_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ast_remote_model (
    input  wire logic clk_i,  // clock
    output var  logic line_o  // serial line
);
    initial line_o = 1'b1;
    task automatic bits(input logic b, input int c);
        line_o = b;
        repeat (c) @(negedge clk_i);
    endtask
    // glitch hits sample 9 of bit 1
    task automatic send(input logic [8:0] d, input int nb, input logic stp, gl);
        bits(1'b0, 16);
        for (int k = 0; k < nb; k++) begin
            bits(d[k], 8);
            bits(d[k] ^ (gl && k == 1), 1);
            bits(d[k], 7);
        end
        bits(stp, 16);
        bits(1'b1, 8);
    endtask
endmodule
`default_nettype wire

// *** sim/ast_transceiver_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module ast_transceiver_checker (
    input wire logic clk_i,           // clk
    input wire logic nrst_i,          // rst
    input wire logic tx_enable_i,     // in
    input wire logic rx_enable_i,     // in
    input wire logic irq_mask_i,      // in
    input wire logic data_rd_i,       // in
    input wire logic tx_pin_o,        // out
    input wire logic tx_pin_oe_o,     // out
    input wire logic tx_complete_o,   // out
    input wire logic rx_full_o,       // out
    input wire logic idle_o,          // out
    input wire logic overrun_o,       // out
    input wire logic noise_flag_o,    // out
    input wire logic framing_error_o, // out
    input wire logic rx_mute_o,       // out
    input wire logic irq_o            // out
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_pin_owner: assert property (tx_pin_oe_o == (tx_enable_i | rx_enable_i)) else $error("pin owner");
    a_idle_first: assert property ($rose(tx_enable_i) && tx_complete_o |=> tx_pin_o [*8]) else $error("idle");
    a_overrun_full: assert property ($rose(overrun_o) |-> $past(rx_full_o)) else $error("overrun");
    a_noise_full: assert property ($rose(noise_flag_o) |-> $rose(rx_full_o)) else $error("noise");
    a_fe_full: assert property ($rose(framing_error_o) |-> $rose(rx_full_o)) else $error("framing");
    a_mute_quiet: assert property (rx_mute_o && $past(rx_mute_o) |-> !$rose(rx_full_o) && !$rose(idle_o))
        else $error("muted flag");
    a_irq_mask: assert property (irq_mask_i |-> !irq_o) else $error("irq masked");
    a_clear_read: assert property ($fell(rx_full_o) |-> $past(data_rd_i)) else $error("rx clear");
endmodule
bind ast_transceiver ast_transceiver_checker u_chk (.*);
`default_nettype wire

// *** sim/tb_ast_transceiver.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_ast_transceiver;
    logic        clk_i = '0, nrst_i = '0, word9_i = '0, tx_enable_i = '0, rx_enable_i = '0, send_break_i = '0;
    logic        wake_method_i = '0, rx_mute_set_i = '0, rx_irq_en_i = '0, irq_mask_i = '0, status_rd_i = '0;
    logic        data_rd_i = '0, tx_valid_i = '0, tx_ready_o, serial_rx_pin_i, tx_pin_o, tx_pin_oe_o, irq_o;
    logic        rx_ninth_bit_o, tx_buffer_empty_o, tx_complete_o, rx_full_o, idle_o, overrun_o;
    logic        noise_flag_o, framing_error_o, rx_mute_o;
    logic [1:0]  prescale_sel_i = '0;
    logic [2:0]  tx_rate_sel_i = '0;
    logic [7:0]  tx_fine_prescaler_i = '0, rx_data_o;
    logic [8:0]  tx_data_i = '0, v, w [16];
    logic [31:0] seed = 32'h4ffa_ca0d;
    int          err_total = 0, comparisons = 0, bp, nb, n;
    ast_transceiver uut (.*, .rx_rate_sel_i(3'h0), .rx_fine_prescaler_i(8'h00), .tx_empty_irq_en_i(1'b0),
        .tx_complete_irq_en_i(1'b0), .idle_irq_en_i(1'b0));
    ast_remote_model rem (.clk_i, .line_o(serial_rx_pin_i));
    initial forever #5 clk_i = ~clk_i;
    function automatic logic [8:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[8:0];
    endfunction
    function automatic int dv(int i);
        int pr[4] = '{1, 3, 4, 13};
        return pr[i] * (i == 1 ? 2 : 1) * (i == 2 ? 3 : 1);
    endfunction
    task automatic chk(input string nm, input logic [8:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic clr();
        pulse(status_rd_i);
        pulse(data_rd_i);
        tick(1);
    endtask
    task automatic cap(output logic [8:0] o);
        o = '0;
        for (int t = 0; t < 30000 && tx_pin_o !== 1'b0; t++)
            tick(1);
        tick(bp / 2);
        chk("start", tx_pin_o, 0);
        for (int k = 0; k < nb; k++) begin
            tick(bp);
            o[k] = tx_pin_o;
        end
        tick(bp);
        chk("stop", tx_pin_o, 1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick(5);
        nrst_i = 1'b1;
        chk("tx_buffer_empty_rst", {tx_buffer_empty_o, tx_pin_o}, 2'b11);
        for (int i = 0; i < 4; i++) begin
            tx_enable_i = 1'b0;
            tick(600);
            chk("tx_flags", {tx_buffer_empty_o, tx_complete_o}, 2'b11);
            pulse(status_rd_i);
            prescale_sel_i = 2'(i);
            tx_rate_sel_i = 3'(i == 1);
            tx_fine_prescaler_i = (i == 2) ? 8'h03 : 8'h00;
            word9_i = i[0];
            nb = 8 + i[0];
            bp = 16 * dv(i);
            n = (i == 0) ? 16 : 1;
            for (int k = 0; k < n; k++) begin
                w[k] = rnd();
                tx_data_i = w[k];
                tx_valid_i = 1'b1;
                tick(1);
            end
            tx_valid_i = 1'b0;
            chk("tx_ready", tx_ready_o, i != 0);
            tx_enable_i = 1'b1;
            tick(bp * 8);
            chk("idle_frame", tx_pin_o, 1);
            chk("tx_cleared", {tx_buffer_empty_o, tx_complete_o}, 2'b00);
            for (int k = 0; k < n; k++) begin
                cap(v);
                chk("tx_word", v, w[k] & (nb == 9 ? 9'h1ff : 9'h0ff));
            end
            $display("tx test %0d done", i);
        end
        send_break_i = 1'b1;
        tick(bp * 12);
        chk("break", tx_pin_o, 0);
        send_break_i = 1'b0;
        tick(bp * 12);
        chk("break_end", tx_pin_o, 1);
        tx_enable_i = 1'b0;
        prescale_sel_i = 2'h0;
        word9_i = 1'b0;
        rx_enable_i = 1'b1;
        rx_irq_en_i = 1'b1;
        tick(200);
        chk("idle", idle_o, 1);
        clr();
        v = rnd();
        rem.send(v, 8, 1'b1, 1'b0);
        chk("rx_word", {irq_o, rx_data_o}, {1'b1, v[7:0]});
        irq_mask_i = 1'b1;
        tick(1);
        chk("irq_mask", irq_o, 0);
        irq_mask_i = 1'b0;
        rem.send(~v, 8, 1'b1, 1'b0);
        chk("overrun", {overrun_o, rx_data_o}, {1'b1, v[7:0]});
        clr();
        chk("cleared", {rx_full_o, overrun_o}, 2'b00);
        v = rnd();
        rem.send(v, 8, 1'b1, 1'b1);
        chk("noise", {noise_flag_o, rx_data_o}, {1'b1, v[7:0]});
        clr();
        rem.bits(1'b0, 8);
        rem.bits(1'b1, 40);
        rem.send(v, 8, 1'b1, 1'b0);
        chk("held_noise", {rx_full_o, noise_flag_o}, 2'b11);
        clr();
        rem.send(9'h000, 8, 1'b0, 1'b0);
        chk("framing", {rx_full_o, framing_error_o}, 2'b11);
        clr();
        word9_i = 1'b1;
        v = rnd();
        rem.send(v, 9, 1'b1, 1'b0);
        chk("ninth", {rx_ninth_bit_o, rx_data_o}, v);
        clr();
        word9_i = 1'b0;
        wake_method_i = 1'b1;
        pulse(rx_mute_set_i);
        rem.send(9'h012, 8, 1'b1, 1'b0);
        chk("muted", {rx_mute_o, rx_full_o}, 2'b10);
        rem.send(9'h09a, 8, 1'b1, 1'b0);
        chk("woken", {rx_mute_o, rx_full_o, rx_data_o[6:0]}, 9'h09a);
        clr();
        wake_method_i = 1'b0;
        pulse(rx_mute_set_i);
        tick(200);
        chk("idle_wake", {rx_mute_o, idle_o}, 2'b00);
        $display("rx tests done");
        finish_test();
    end
    initial begin
        repeat (50000) @(posedge clk_i);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
